// >>> pcc_consts.vh
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
// Register addresses
`define PCC_ADDR_PORT_CONFIG 8'h00
`define PCC_ADDR_PORT_THREE_MODE 8'hf7
`define PCC_BANK_F 4'hf
// Port configuration fields
`define PCC_PCFG_CMP_OUT 0
`define PCC_PCFG_P1_PUSHPULL 1
`define PCC_PCFG_P0_PUSHPULL 2
`define PCC_PCFG_P0_STD 3
`define PCC_PCFG_P1_STD 4
`define PCC_PCFG_P2_STD 5
`define PCC_PCFG_P3_STD 6
`define PCC_PCFG_OSC_STD 7
`define PCC_PCFG_RESET 8'hfe
// Port three mode fields
`define PCC_P3M_P2_PUSHPULL 0
`define PCC_P3M_ANALOG 1
`define PCC_P3M_RESET 8'h00
// Interrupt edge select bits
`define PCC_IRQ_EDGE_LO 6
`define PCC_IRQ_EDGE_HI 7
`endif

// >>> pcc_port3_cmp.v
// What this block does
// R1 - Mode bit D1 picks digital (0) or analog (1) for three comparator lines
// R2 - Comparator output high when positive input exceeds shared reference
// R3 - In analog mode, data read gives comparator one in D1, two in D2
// R4 - Config bit D0 set routes comparator results onto port three outputs
// R5 - Stored output bits stay intact while routed and return afterwards
// R6 - Reference line raises no interrupt in analog mode, only in digital
// R7 - In analog mode comparator lines interrupt on edges chosen by bits 6, 7
// R8 - D7:D6=00 comparator two interrupts on low; 10 both lines interrupt
// R9 - Comparators and their interrupts keep working in halt mode
// R10 - Comparators off in stop; stop recovery sensing only in digital mode; the code still senses P30 in analog mode
// R11 - Analog mode selection survives a stop-recovery reset
// R12 - First line stays timer input; in analog mode it follows comparator one
// R13 - Mode bit D0 makes port two open-drain at 0, push-pull at 1
// R14 - Config bit D1 makes port one open-drain at 0, push-pull at 1, default 1
// R15 - Config bit D2 makes port zero open-drain at 0, push-pull at 1, default 1
// R16 - Config bits D3..D6 set low-EMI per port zero..three at 0, default 1
// R17 - Config bit D7 low-noise oscillator at 0, standard at 1, default 1
// R18 - Config register write-only at bank F 00h; mode register write-only at F7h
// R19 - Lines P30..P32 feed interrupt requests in both modes; P33 in digital mode only
// R20 - Comparator results pass a two-stage synchroniser before use
`timescale 1ns/1ps
`include "pcc_consts.vh"
module pcc_port3_cmp (
   // Clock and reset
   input wire clk_sys,
   input wire resetn,
   input wire clk_en,
   // Register file write port
   input wire reg_wr,
   input wire [7:0] reg_addr,
   input wire [3:0] reg_bank,
   input wire [7:0] reg_wdata,
   // Interrupt edge select from the interrupt request register
   input wire [7:0] irq_reg,
   // Power states
   input wire halt_mode,
   input wire stop_mode,
   input wire stop_recovery_reset,
   // Port three pins, inputs are digital levels
   input wire [3:0] p3_in,
   // Raw analog comparator decisions
   input wire cmp_one_raw,
   input wire cmp_two_raw,
   // Stored port three output register
   input wire [7:4] p3_out_reg,
   // Port three read data and pin drive
   output reg [3:0] p3_read,
   output reg [7:4] p3_pin_out,
   // Interrupt requests for P30..P33 lines
   output reg [3:0] irq_req,
   output reg timer_in,
   output reg [3:0] stop_recovery_sense,
   // Port configuration outputs
   output reg p0_push_pull,
   output reg p1_push_pull,
   output reg p2_push_pull,
   output reg [3:0] port_std_drive,
   output reg osc_std_drive,
   output reg cmp_enable,
   output reg analog_mode
);

////////////////////////////////////////////////////////////////////////////////
reg [7:0] port_config_reg;
reg [7:0] port_three_mode_reg;
reg cmp_one_meta, cmp_one_result;
reg cmp_two_meta, cmp_two_result;
reg cmp_one_prev, cmp_two_prev;
reg [3:0] din_prev;
wire wr_mode;
wire wr_cfg;
wire analog;

assign wr_mode = reg_wr && reg_addr == `PCC_ADDR_PORT_THREE_MODE; // R18
assign wr_cfg = reg_wr && reg_addr == `PCC_ADDR_PORT_CONFIG && reg_bank == `PCC_BANK_F; // R18
assign analog = port_three_mode_reg[`PCC_P3M_ANALOG]; // R1

// Edge decode shared by both comparator lines
function edge_hit;
   input [1:0] sel;
   input prev;
   input cur;
   begin
      case (sel)
         2'b00: edge_hit = prev & ~cur;
         2'b01: edge_hit = ~prev & cur;
         2'b10: edge_hit = prev ^ cur;
         default: edge_hit = 1'b0;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers; a stop-recovery reset deliberately leaves the mode register alone
always @(posedge clk_sys) begin
   if (!resetn) begin
      port_config_reg <= `PCC_PCFG_RESET; // R14 R15 R16 R17
      port_three_mode_reg <= `PCC_P3M_RESET;
   end else if (clk_en) begin
      if (stop_recovery_reset) begin
         port_config_reg <= port_config_reg; // R11
      end else begin
         if (wr_cfg) begin
            port_config_reg <= reg_wdata; // R18
         end
         if (wr_mode) begin
            port_three_mode_reg <= reg_wdata; // R18
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Synchroniser; first stage is read only by the second
always @(posedge clk_sys) begin
   if (!resetn) begin
      cmp_one_meta <= 1'b0;
      cmp_one_result <= 1'b0;
      cmp_two_meta <= 1'b0;
      cmp_two_result <= 1'b0;
      cmp_one_prev <= 1'b0;
      cmp_two_prev <= 1'b0;
      din_prev <= 4'h0;
   end else if (clk_en) begin
      cmp_one_meta <= cmp_one_raw; // R20 R2
      cmp_one_result <= cmp_one_meta; // R20
      cmp_two_meta <= cmp_two_raw; // R20 R2
      cmp_two_result <= cmp_two_meta; // R20
      cmp_one_prev <= cmp_one_result;
      cmp_two_prev <= cmp_two_result;
      din_prev <= p3_in;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Next values for the port three side
reg [3:0] next_p3_read;
reg next_timer_in;
reg [7:4] next_p3_pin_out;
reg [3:0] next_irq_req;
reg [3:0] next_stop_recovery_sense;
wire [1:0] edge_sel;
wire cmp_live;

assign edge_sel = irq_reg[`PCC_IRQ_EDGE_HI:`PCC_IRQ_EDGE_LO]; // R7
// Comparators are powered down in stop, so their lines stay quiet there
assign cmp_live = analog && !stop_mode; // R9 R10

// Falling edge of a digital input line
function fell_edge;
   input prev;
   input cur;
   begin
      fell_edge = prev & ~cur;
   end
endfunction

// Read path
always @* begin
   if (analog) begin
      next_p3_read = {p3_in[3], cmp_two_result, cmp_one_result, p3_in[0]}; // R3
   end else begin
      next_p3_read = p3_in;
   end
end

// Timer input; in analog mode it sees the reference comparison, not the raw level
always @* begin
   if (analog) begin
      next_timer_in = cmp_one_result; // R12
   end else begin
      next_timer_in = p3_in[1]; // R12
   end
end

// Pin drive; the stored bits live outside and are never overwritten here
always @* begin
   if (port_config_reg[`PCC_PCFG_CMP_OUT]) begin
      next_p3_pin_out = {cmp_two_result, p3_out_reg[6], cmp_two_result, cmp_one_result}; // R4
   end else begin
      next_p3_pin_out = p3_out_reg; // R5
   end
end

// Interrupt requests, one per input line
always @* begin
   next_irq_req[0] = fell_edge(din_prev[0], p3_in[0]); // R19
   if (analog) begin
      next_irq_req[3] = 1'b0; // R6
      next_irq_req[1] = cmp_live && edge_sel == 2'b10 && edge_hit(2'b10, cmp_one_prev, cmp_one_result); // R7 R8 R9
      next_irq_req[2] = cmp_live && edge_hit(edge_sel, cmp_two_prev, cmp_two_result); // R7 R8 R9
   end else begin
      next_irq_req[3] = fell_edge(din_prev[3], p3_in[3]); // R6 R19
      next_irq_req[2] = fell_edge(din_prev[2], p3_in[2]); // R19
      next_irq_req[1] = fell_edge(din_prev[1], p3_in[1]); // R19
   end
end

// Only P30 stays digital in analog mode, so it alone can end a stop
always @* begin
   if (analog) begin
      next_stop_recovery_sense = {3'b000, p3_in[0]}; // R10
   end else begin
      next_stop_recovery_sense = p3_in; // R10
   end
end

////////////////////////////////////////////////////////////////////////////////
// Port three outputs from flip-flops
always @(posedge clk_sys) begin
   if (!resetn) begin
      p3_read <= 4'h0;
   end else if (clk_en) begin
      p3_read <= next_p3_read; // R3
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      timer_in <= 1'b0;
   end else if (clk_en) begin
      timer_in <= next_timer_in; // R12
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      p3_pin_out <= 4'h0;
   end else if (clk_en) begin
      p3_pin_out <= next_p3_pin_out; // R4 R5
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      irq_req <= 4'h0;
   end else if (clk_en) begin
      irq_req <= next_irq_req; // R6 R7 R8 R19
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      stop_recovery_sense <= 4'h0;
   end else if (clk_en) begin
      stop_recovery_sense <= next_stop_recovery_sense; // R10
   end
end

////////////////////////////////////////////////////////////////////////////////
// Decoded configuration; each output lags its register by one edge
always @(posedge clk_sys) begin
   if (!resetn) begin
      analog_mode <= 1'b0;
   end else if (clk_en) begin
      analog_mode <= analog; // R1
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      cmp_enable <= 1'b0;
   end else if (clk_en) begin
      cmp_enable <= cmp_live; // R9 R10
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      p2_push_pull <= 1'b0;
   end else if (clk_en) begin
      p2_push_pull <= port_three_mode_reg[`PCC_P3M_P2_PUSHPULL]; // R13
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      p1_push_pull <= 1'b1;
   end else if (clk_en) begin
      p1_push_pull <= port_config_reg[`PCC_PCFG_P1_PUSHPULL]; // R14
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      p0_push_pull <= 1'b1;
   end else if (clk_en) begin
      p0_push_pull <= port_config_reg[`PCC_PCFG_P0_PUSHPULL]; // R15
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      port_std_drive <= 4'hf;
   end else if (clk_en) begin
      port_std_drive <= port_config_reg[`PCC_PCFG_P3_STD:`PCC_PCFG_P0_STD]; // R16
   end
end

always @(posedge clk_sys) begin
   if (!resetn) begin
      osc_std_drive <= 1'b1;
   end else if (clk_en) begin
      osc_std_drive <= port_config_reg[`PCC_PCFG_OSC_STD]; // R17
   end
end

endmodule // pcc_port3_cmp

// >>> pcc_analog_model.sv
`timescale 1ns/1ps
module pcc_analog_model (
   // Pin voltages in millivolts
   input int v1,
   input int v2,
   input int vref,
   // Comparator decisions
   output logic cmp_one_raw,
   output logic cmp_two_raw
);
   // Equal voltages read low; a real front end is ambiguous there
   assign cmp_one_raw = v1 > vref;
   assign cmp_two_raw = v2 > vref;
endmodule // pcc_analog_model

// >>> pcc_chk_assertions.sv
`timescale 1ns/1ps
module pcc_chk (
   // Clock, reset and writes
   input wire clk_sys, resetn, clk_en, reg_wr, stop_recovery_reset, stop_mode,
   input wire [3:0] reg_bank,
   input wire [7:0] reg_addr, reg_wdata, irq_reg,
   // Outputs watched
   input wire cmp_one_raw, cmp_two_raw, timer_in, p0_push_pull, p1_push_pull,
   input wire p2_push_pull, osc_std_drive, cmp_enable, analog_mode,
   input wire [3:0] p3_read, irq_req, port_std_drive
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   wire wr_ok = reg_wr && clk_en && !stop_recovery_reset;
   a_mode_write: assert property (wr_ok && reg_addr == 8'hf7 |=> ##1 analog_mode == $past(reg_wdata[1], 2))
      else $error("mode bit not applied");
   a_p2_drive: assert property (wr_ok && reg_addr == 8'hf7 |=> ##1 p2_push_pull == $past(reg_wdata[0], 2))
      else $error("port two drive not applied");
   a_cfg_write: assert property (wr_ok && reg_bank == 4'hf && reg_addr == 8'h00 |=> ##1
      {osc_std_drive, port_std_drive, p0_push_pull, p1_push_pull} == $past(reg_wdata[7:1], 2))
      else $error("config bits not applied");
   a_stop_off: assert property (stop_mode ##1 stop_mode |-> !cmp_enable)
      else $error("comparator on in stop");
   a_read_cmp: assert property ((analog_mode && !stop_mode && $stable({cmp_one_raw, cmp_two_raw}))[*4]
      |-> p3_read[2:1] == {cmp_two_raw, cmp_one_raw}) else $error("read bits wrong");
   a_timer_cmp: assert property ((analog_mode && !stop_mode && $stable(cmp_one_raw))[*4]
      |-> timer_in == cmp_one_raw) else $error("timer input wrong");
   a_ref_quiet: assert property (analog_mode[*4] |-> !irq_req[3])
      else $error("reference line interrupted");
   a_fall_two: assert property (analog_mode && !stop_mode && irq_reg[7:6] == 2'b00 && $fell(cmp_two_raw)
      |-> ##3 irq_req[2]) else $error("no falling interrupt");
   a_rise_one: assert property (analog_mode && !stop_mode && irq_reg[7:6] == 2'b10 && $rose(cmp_one_raw)
      |-> ##3 irq_req[1]) else $error("no rising interrupt");
   c_two: cover property (analog_mode && irq_req[2]);
   c_one: cover property (analog_mode && irq_req[1]);
   c_read: cover property (analog_mode && p3_read[1]);
endmodule // pcc_chk
////////////////////////////////
bind pcc_port3_cmp pcc_chk chk(.*);

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   logic clk_sys = 0, resetn = 0, clk_en = 1, reg_wr = 0, halt_mode = 0, stop_mode = 0, stop_recovery_reset = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, irq_reg = 0;
   logic [3:0] reg_bank = 0, p3_in = 4'hf, seen = 0;
   logic [7:4] p3_out_reg = 4'ha;
   logic seen_clr = 0;
   int v1 = 0, v2 = 0, vref = 50, num_errors = 0, compares = 0, i;
   wire cmp_one_raw, cmp_two_raw, timer_in, p0_push_pull, p1_push_pull, p2_push_pull;
   wire osc_std_drive, cmp_enable, analog_mode;
   wire [3:0] p3_read, irq_req, stop_recovery_sense, port_std_drive;
   wire [7:4] p3_pin_out;
   wire [9:0] cfg = {osc_std_drive, port_std_drive, p0_push_pull, p1_push_pull, p2_push_pull, analog_mode, cmp_enable};
   pcc_port3_cmp uut(.*);
   pcc_analog_model amod(.v1(v1), .v2(v2), .vref(vref), .cmp_one_raw(cmp_one_raw), .cmp_two_raw(cmp_two_raw));
   always #5 clk_sys = ~clk_sys;
   // Pulses are one cycle wide, so collect them
   always @(posedge clk_sys) seen <= seen_clr ? irq_req : seen | irq_req;
   ////////////////////////////////
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task clr;
      seen_clr = 1;
      wt(1);
      seen_clr = 0;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
      reg_bank = b; reg_addr = a; reg_wdata = d; reg_wr = 1;
      wt(1);
      reg_wr = 0;
      wt(1);
   endtask
   task final_report;
      if (num_errors == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////
   initial begin
      wt(2);
      resetn = 1;
      chk(cfg, 10'h3f8);
      for (i = 1; i < 8; i++) begin
         wr(4'hf, 8'h00, 8'hff ^ (8'h01 << i));
         chk(cfg[9:3], 7'h7f ^ (7'h01 << (i - 1)));
      end
      wr(4'hf, 8'h00, 8'hfe); wr(4'he, 8'h00, 8'h00); wr(4'hf, 8'hf6, 8'h03);
      chk(cfg, 10'h3f8);
      wr(4'h0, 8'hf7, 8'h03);
      chk(cfg[2:0], 3'h7);
      v1 = 80; wt(4);
      chk(p3_read[2:1], 2'h1);
      chk(timer_in, 1'h1);
      wr(4'hf, 8'h00, 8'hff);
      chk(p3_pin_out, 4'h1);
      wr(4'hf, 8'h00, 8'hfe);
      chk(p3_pin_out, 4'ha);
      halt_mode = 1;
      for (i = 0; i < 4; i++) begin
         irq_reg = {i[1:0], 6'h00}; v1 = 0; v2 = 0; wt(5);
         clr; v1 = 80; v2 = 80; wt(5);
         v1 = 0; v2 = 0; p3_in = 0; wt(5);
         chk(seen, (16'h1755 >> (4 * i)) & 16'h000f);
         p3_in = 4'hf;
      end
      halt_mode = 0; stop_mode = 1; wt(2);
      chk(cmp_enable, 1'h0);
      chk(stop_recovery_sense, 4'h1);
      irq_reg = 8'h80; clr; v2 = 80; wt(5);
      chk(seen, 4'h0);
      stop_recovery_reset = 1; wt(2); stop_recovery_reset = 0; stop_mode = 0; wt(2);
      chk(analog_mode, 1'h1);
      wr(4'h0, 8'hf7, 8'h00); wt(3);
      clr; p3_in = 4'h7; wt(5);
      chk(seen, 4'h8);
      chk(stop_recovery_sense, 4'h7);
      final_report;
   end
   // Run needs about 120 cycles
   initial begin
      #100000;
      num_errors++;
      final_report;
   end
endmodule // tb
